// ---- dv/lndrs_ram_model.sv ----
/* Buffer RAM partner: word memory answering each request with a one-cycle ack.
   Assumes the sequencer holds its request until acked; addresses below 512. */
module lndrs_ram_model
(
   input wire logic clk_sys_in,
   input wire logic mem_req_in,
   input wire logic mem_we_in,
   input wire logic [23:0] mem_addr_in,
   input wire logic [15:0] mem_wdata_in,
   output logic mem_ack_out = 1'b0,
   output logic [15:0] mem_rdata_out = 16'h0
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [256];
   logic [1:0] cnt_r = 2'h0;
   logic slow_r = 1'b0;
   // Alternate prompt and slow answers; idle read data keeps toggling
   always @(posedge clk_sys_in)
   begin
      mem_ack_out <= 1'b0;
      mem_rdata_out <= ~mem_rdata_out;
      if (mem_req_in && !mem_ack_out)
      begin
         if (cnt_r == {slow_r, 1'b0})
         begin
            mem_ack_out <= 1'b1;
            cnt_r <= 2'h0;
            slow_r <= ~slow_r;
            if (mem_we_in)
               mem[mem_addr_in[8:1]] <= mem_wdata_in;
            else
               mem_rdata_out <= mem[mem_addr_in[8:1]];
         end
         else
            cnt_r <= cnt_r + 2'h1;
      end
   end
endmodule // lndrs_ram_model

// ---- dv/testbench.sv ----
/* Self-checking bench for the descriptor ring sequencer.
   Assumes the RAM partner model and a shortened idle wait. */
module testbench
   import lndrs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_in = 1'b0, rst_in = 1'b1, csr_wr_in = 1'b0, mem_req_out, mem_we_out, mem_ack_in;
   logic tx_start_out, tx_chain_out, tx_retry_out, tx_abort_out, rx_enter_out, collision_in = 1'b0;
   logic slot_elapsed_in = 1'b0, carrier_in = 1'b1, silo_underflow_in = 1'b0, buffer_sent_in = 1'b0;
   logic rx_frame_in = 1'b0, dest_station_match_in = 1'b0, dest_broadcast_in = 1'b0;
   logic dest_multicast_pass_in = 1'b0, rx_release_in = 1'b0;
   logic [1:0] csr_sel_in = 2'h0;
   logic [15:0] csr_wdata_in = 16'h0, csr_rdata_out, mem_wdata_out, mem_rdata_in, d;
   logic [23:0] mem_addr_out, tx_addr_out;
   logic [11:0] tx_len_out;
   logic [35:0] exp_q [$];
   logic [31:0] rnd = 32'h007f59c8;
   int num_errors = 0;
   int comparisons = 0;
   lndrs_top #(.WAIT_CYC(20)) i_lndrs_top (.clk_sys_in, .rst_in, .csr_wr_in, .csr_sel_in,
      .csr_wdata_in, .csr_rdata_out, .mem_req_out, .mem_we_out, .mem_addr_out, .mem_wdata_out,
      .mem_ack_in, .mem_rdata_in, .tx_start_out, .tx_chain_out, .tx_retry_out, .tx_abort_out,
      .tx_addr_out, .tx_len_out, .collision_in, .slot_elapsed_in, .carrier_in,
      .silo_underflow_in, .buffer_sent_in, .rx_frame_in, .dest_station_match_in,
      .dest_broadcast_in, .dest_multicast_pass_in, .rx_release_in, .rx_enter_out);
   lndrs_ram_model i_ram (.clk_sys_in(clk_sys_in), .mem_req_in(mem_req_out),
      .mem_we_in(mem_we_out), .mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out),
      .mem_ack_out(mem_ack_in), .mem_rdata_out(mem_rdata_in));
   initial forever #5 clk_sys_in = ~clk_sys_in;
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
      comparisons++;
      if (g !== e)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic results();
      $display("Comparisons %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(input logic [1:0] s, input logic [15:0] v);
      csr_sel_in = s;
      csr_wdata_in = v;
      csr_wr_in = 1'b1;
      @(negedge clk_sys_in);
      csr_wr_in = 1'b0;
      @(negedge clk_sys_in);
   endtask
   task automatic rd(input logic [1:0] s);
      csr_sel_in = s;
      repeat (2) @(negedge clk_sys_in);
      d = csr_rdata_out;
   endtask
   // Wait for the sequencer to hand a descriptor back, then 50 cycles more
   task automatic wait_free(input int w);
      for (int i = 0; i < 500 && i_ram.mem[w][15] !== 1'b0; i++) @(negedge clk_sys_in);
      chk("own", 36'h0, 36'(i_ram.mem[w][15]));
      repeat (50) @(negedge clk_sys_in);
   endtask
   task automatic wait_start();
      for (int i = 0; i < 500 && exp_q.size() != 0; i++) @(negedge clk_sys_in);
      chk("start seen", 36'h0, 36'(exp_q.size()));
   endtask
   // Take the oldest note whenever a packet start or a chained buffer appears
   always @(negedge clk_sys_in)
      if (tx_start_out === 1'b1 || tx_chain_out === 1'b1)
         chk("start", exp_q.size() ? exp_q.pop_front() : 36'h0, {tx_addr_out, tx_len_out});
   initial
   begin
      #200us;
      num_errors++;
      results();
   end
   // Main sequence: init block at 0x10, rx ring 0x20, two-entry tx ring 0x40
   initial
   begin
      foreach (i_ram.mem[i]) i_ram.mem[i] = 16'h0;
      i_ram.mem[9] = 16'h0020;
      i_ram.mem[10] = 16'h2000;
      i_ram.mem[11] = 16'h0040;
      i_ram.mem[12] = 16'h2000;
      rnd = xorshift(rnd);
      i_ram.mem[32] = rnd[15:0];
      i_ram.mem[34] = {4'hf, rnd[27:16]};
      i_ram.mem[33] = {8'h83, rnd[31:24]};
      i_ram.mem[36] = 16'h1234;
      i_ram.mem[38] = 16'hffc0;
      i_ram.mem[37] = 16'h0300;
      exp_q.push_back({rnd[31:24], rnd[15:0], rnd[27:16]});
      repeat (20) @(negedge clk_sys_in);
      rst_in = 1'b0;
      rd(2'h0);
      chk("halted", 36'h4, 36'(d[2:0]));
      wr(2'h1, 16'h0010);
      wr(2'h2, 16'h0000);
      wr(2'h0, 16'h0033);
      wait_start();
      buffer_sent_in = 1'b1;
      @(negedge clk_sys_in);
      buffer_sent_in = 1'b0;
      wait_free(33);
      chk("status", 36'h03, 36'(i_ram.mem[33][15:8]));
      rd(2'h3);
      chk("txp", 36'h1, 36'(d[14:8]));
      rx_frame_in = 1'b1;
      dest_broadcast_in = 1'b1;
      @(negedge clk_sys_in);
      rx_frame_in = 1'b0;
      chk("rx enter", 36'h1, 36'(rx_enter_out));
      dest_broadcast_in = 1'b0;
      @(negedge clk_sys_in);
      rx_frame_in = 1'b1;
      @(negedge clk_sys_in);
      rx_frame_in = 1'b0;
      chk("rx ignore", 36'h0, 36'(rx_enter_out));
      wr(2'h0, 16'h0004);
      rd(2'h0);
      chk("halt", 36'h4, 36'(d[2:0]));
      rd(2'h3);
      chk("txp kept", 36'h1, 36'(d[14:8]));
      i_ram.mem[37] = 16'h8300;
      exp_q.push_back({8'h00, 16'h1234, 12'hfc0});
      wr(2'h0, 16'h002a);
      wait_start();
      collision_in = 1'b1;
      slot_elapsed_in = 1'b1;
      @(negedge clk_sys_in);
      collision_in = 1'b0;
      slot_elapsed_in = 1'b0;
      chk("abort", 36'h1, 36'(tx_abort_out));
      wait_free(37);
      chk("err sum", 36'h1, 36'(i_ram.mem[37][15:14]));
      chk("late", 36'h1000, 36'(i_ram.mem[39] & 16'hfc00));
      rd(2'h3);
      chk("txp wrap", 36'h0, 36'(d[14:8]));
      // Two-buffer packet with one early collision
      i_ram.mem[32] = 16'h0100;
      i_ram.mem[34] = 16'hff00;
      i_ram.mem[36] = 16'h0200;
      i_ram.mem[38] = 16'hfe00;
      i_ram.mem[37] = 16'h8100;
      i_ram.mem[33] = 16'h8200;
      exp_q.push_back({8'h00, 16'h0100, 12'hf00});
      wait_start();
      exp_q.push_back({8'h00, 16'h0200, 12'he00});
      collision_in = 1'b1;
      @(negedge clk_sys_in);
      collision_in = 1'b0;
      chk("retry", 36'h1, 36'(tx_retry_out));
      buffer_sent_in = 1'b1;
      @(negedge clk_sys_in);
      buffer_sent_in = 1'b0;
      wait_start();
      buffer_sent_in = 1'b1;
      @(negedge clk_sys_in);
      buffer_sent_in = 1'b0;
      wait_free(37);
      chk("one retry", 36'h0a00, 36'(i_ram.mem[33]));
      chk("chained end", 36'h0900, 36'(i_ram.mem[37]));
      // Unended buffer whose next descriptor is host-owned
      i_ram.mem[33] = 16'h8200;
      exp_q.push_back({8'h00, 16'h0100, 12'hf00});
      wait_start();
      buffer_sent_in = 1'b1;
      @(negedge clk_sys_in);
      buffer_sent_in = 1'b0;
      wait_free(33);
      chk("buffer err", 36'hc000, 36'(i_ram.mem[35]));
      chk("err word", 36'h4200, 36'(i_ram.mem[33]));
      results();
   end
endmodule // testbench

// ---- hw/lndrs_pkg.sv ----
/*
 * Constants for the descriptor ring sequencer: control register indices and
 * bits, descriptor word and field positions, parameter block layout, reset
 * values and timing.
 * Assumes a 100 MHz system clock and 16-bit words in buffer RAM.
 */
package lndrs_pkg;

   // Clock and look-for-work idle delay
   localparam int CLK_PERIOD_NS = 10;
   localparam real LFW_WAIT_MS = 1.6;
   localparam int LFW_WAIT_CYC = int'(LFW_WAIT_MS * 1.0e6) / CLK_PERIOD_NS;
   localparam int WAIT_W = 18;

   // Control register indices on the host port
   localparam logic [1:0] CSR0_IDX = 2'h0;
   localparam logic [1:0] CSR1_IDX = 2'h1;
   localparam logic [1:0] CSR2_IDX = 2'h2;
   localparam logic [1:0] CSR3_IDX = 2'h3;

   // Control register 0 bit positions
   localparam int CSR0_INIT_BIT = 0;
   localparam int CSR0_RUN_BIT = 1;
   localparam int CSR0_HALT_BIT = 2;
   localparam int CSR0_TRANSMIT_DEMAND_BIT = 3;
   localparam int CSR0_RECEIVER_ON_BIT = 4;
   localparam int CSR0_TRANSMITTER_ON_BIT = 5;
   localparam int CSR0_IDONE_BIT = 6;
   localparam logic CSR0_HALT_RST = 1'b1;

   // Descriptor word indices (byte offset is twice the index)
   localparam logic [1:0] DW_ADDR_LO = 2'h0;
   localparam logic [1:0] DW_FLAGS = 2'h1;
   localparam logic [1:0] DW_SIZE = 2'h2;
   localparam logic [1:0] DW_STATUS = 2'h3;

   // Descriptor word 1 fields, size field width and distance field width
   localparam int W1_OWN_BIT = 15;
   localparam int W1_ERRSUM_BIT = 14;
   localparam int W1_STP_BIT = 9;
   localparam int W1_ENP_BIT = 8;
   localparam int SIZE_W = 12;
   localparam int TDR_W = 10;

   // Parameter block word indices and fields
   localparam logic [2:0] IB_MODE = 3'h0;
   localparam logic [2:0] IB_RX_LO = 3'h1;
   localparam logic [2:0] IB_RX_HI = 3'h2;
   localparam logic [2:0] IB_TX_LO = 3'h3;
   localparam logic [2:0] IB_TX_HI = 3'h4;
   localparam logic [2:0] IB_WORDS = 3'h5;
   localparam int IB_LEN_LSB = 13;
   localparam int MODE_DISABLE_RETRY_BIT = 5;
   localparam int MODE_PROMISCUOUS_BIT_BIT = 15;

   // Collision attempt limit
   localparam logic [4:0] MAX_ATTEMPTS = 5'h10;

endpackage : lndrs_pkg

// ---- hw/lndrs_top.sv ----
/*
 * Descriptor ring sequencer of a network controller: halt/initialise/start
 * switch, parameter block load, look-for-work loop, transmit descriptor
 * handling with status write-back, and receive ring polling.
 * Assumes a buffer RAM that answers each request with a one-cycle ack, and a
 * transmit datapath that reports collisions, carrier, underflow and buffer end.
 */
module lndrs_top
   import lndrs_pkg::*;
#(
   parameter int WAIT_CYC = LFW_WAIT_CYC
)
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic csr_wr_in,
   input wire logic [1:0] csr_sel_in,
   input wire logic [15:0] csr_wdata_in,
   output logic [15:0] csr_rdata_out,
   output logic mem_req_out,
   output logic mem_we_out,
   output logic [23:0] mem_addr_out,
   output logic [15:0] mem_wdata_out,
   input wire logic mem_ack_in,
   input wire logic [15:0] mem_rdata_in,
   output logic tx_start_out,
   output logic tx_chain_out,
   output logic tx_retry_out,
   output logic tx_abort_out,
   output logic [23:0] tx_addr_out,
   output logic [11:0] tx_len_out,
   input wire logic collision_in,
   input wire logic slot_elapsed_in,
   input wire logic carrier_in,
   input wire logic silo_underflow_in,
   input wire logic buffer_sent_in,
   input wire logic rx_frame_in,
   input wire logic dest_station_match_in,
   input wire logic dest_broadcast_in,
   input wire logic dest_multicast_pass_in,
   input wire logic rx_release_in,
   output logic rx_enter_out
);

   typedef enum logic [3:0] {
      S_SWITCH, S_INIT_RD, S_LFW, S_RXPOLL, S_TXCHK, S_TXPOLL, S_TXRD0, S_TXRD2,
      S_TXRUN, S_PF1, S_PF0, S_PF2, S_WR3, S_WR1, S_GAP, S_WAIT
   } lndrs_state_e;

   typedef struct packed {
      lndrs_state_e st;
      logic init, run, halt, transmit_demand, receiver_on, transmitter_on, idone;
      logic [15:0] csr1;
      logic [7:0] csr2;
      logic [15:0] mode;
      logic [23:0] rx_base, tx_base;
      logic [2:0] rx_len, tx_len;
      logic [6:0] receive_ring_pointer, transmit_ring_pointer;
      logic rx_held;
      logic [2:0] iw;
      logic [15:0] cur_w0, cur_w1, cur_w2, nx_w0, nx_w1, nx_w2;
      logic nx_valid, pf_tried, chain, txing, did_tx, bdone;
      logic buf_err, unf, late, car, retries_exhausted;
      logic [TDR_W-1:0] tcnt, cable_fault_distance;
      logic [4:0] attempts;
      logic [WAIT_W-1:0] wait_cnt;
      logic mreq, mwe;
      logic [23:0] maddr;
      logic [15:0] mwdata;
      logic tx_start, tx_chain, tx_retry, tx_abort, rx_enter;
      logic [15:0] csr_rdata;
   } lndrs_state_s;

   lndrs_state_s s_r, s_nxt;
   logic err_any, err_sum;
   logic [15:0] w1_wb, w3_wb;

   // Byte address of a descriptor word in a ring
   function automatic logic [23:0] desc_addr(input logic [23:0] base,
                                             input logic [6:0] ptr,
                                             input logic [1:0] w);
      return base + 24'({ptr, 3'h0}) + 24'({w, 1'b0});
   endfunction

   // Next ring index, wrapping at two to the power of the length code
   function automatic logic [6:0] ring_next(input logic [6:0] ptr, input logic [2:0] lenc);
      logic [7:0] m;
      m = 8'(8'h01 << lenc) - 8'h01;
      return 7'(ptr + 7'h01) & m[6:0];
   endfunction

   // Status write-back words
   assign err_any = s_r.buf_err | s_r.unf | s_r.late | s_r.car | s_r.retries_exhausted;
   assign err_sum = s_r.late | s_r.car | s_r.unf | s_r.retries_exhausted;
   assign w3_wb = {s_r.buf_err, s_r.unf, 1'b0, s_r.late, s_r.car, s_r.retries_exhausted, s_r.cable_fault_distance};
   // Ownership cleared in the same word that carries the summary
   assign w1_wb = {1'b0, s_r.cur_w1[W1_ERRSUM_BIT] | err_sum, 1'b0,
                   s_r.attempts > 5'h01, s_r.attempts == 5'h01, s_r.cur_w1[10:0]};

   // Next-state logic for the whole sequencer
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.tx_start = 1'b0;
      s_nxt.tx_chain = 1'b0;
      s_nxt.tx_retry = 1'b0;
      s_nxt.tx_abort = 1'b0;
      s_nxt.rx_enter = 1'b0;

      // Host read data
      case (csr_sel_in)
         CSR0_IDX: s_nxt.csr_rdata = {9'h000, s_r.idone, s_r.transmitter_on, s_r.receiver_on, s_r.transmit_demand,
                                    s_r.halt, s_r.run, s_r.init};
         CSR1_IDX: s_nxt.csr_rdata = s_r.csr1;
         CSR2_IDX: s_nxt.csr_rdata = {8'h00, s_r.csr2};
         default: s_nxt.csr_rdata = {1'b0, s_r.transmit_ring_pointer, 1'b0, s_r.receive_ring_pointer};
      endcase

      // Transmit event capture while a buffer is on the wire
      if (s_r.txing)
      begin
         s_nxt.tcnt = s_r.tcnt + 10'h001;
         if (buffer_sent_in)
            s_nxt.bdone = 1'b1;
      end
      if (s_r.txing && !err_any)
      begin
         if (collision_in && slot_elapsed_in)
            s_nxt.late = 1'b1;
         else if (collision_in)
         begin
            s_nxt.attempts = s_r.attempts + 5'h01;
            s_nxt.cable_fault_distance = s_r.tcnt;
            if (s_r.mode[MODE_DISABLE_RETRY_BIT] || s_nxt.attempts == MAX_ATTEMPTS)
               s_nxt.retries_exhausted = 1'b1;
            else
            begin
               s_nxt.tx_retry = 1'b1;
               s_nxt.tcnt = '0;
            end
         end
         if (!carrier_in)
            s_nxt.car = 1'b1;
         if (silo_underflow_in)
            s_nxt.unf = 1'b1;
      end

      // Receive side: release of the held descriptor and frame acceptance
      if (rx_release_in && s_r.rx_held)
      begin
         s_nxt.rx_held = 1'b0;
         s_nxt.receive_ring_pointer = ring_next(s_r.receive_ring_pointer, s_r.rx_len);
      end
      if (rx_frame_in && s_r.receiver_on && s_r.run && s_r.st != S_SWITCH && s_r.st != S_INIT_RD
          && (dest_station_match_in || dest_broadcast_in || dest_multicast_pass_in
              || s_r.mode[MODE_PROMISCUOUS_BIT_BIT]))
         s_nxt.rx_enter = 1'b1;

      // Sequencer
      case (s_r.st)
         S_SWITCH:
         begin
            if (!s_r.halt && s_r.init && !s_r.idone)
            begin
               s_nxt.st = S_INIT_RD;
               s_nxt.iw = '0;
               s_nxt.mreq = 1'b1;
               s_nxt.mwe = 1'b0;
               s_nxt.maddr = {s_r.csr2, s_r.csr1};
            end
            else if (!s_r.halt && s_r.run)
               s_nxt.st = S_LFW;
         end
         S_INIT_RD:
            if (mem_ack_in)
            begin
               case (s_r.iw)
                  IB_MODE: s_nxt.mode = mem_rdata_in;
                  IB_RX_LO: s_nxt.rx_base[15:0] = mem_rdata_in;
                  IB_RX_HI: {s_nxt.rx_len, s_nxt.rx_base[23:16]} =
                     {mem_rdata_in[15:IB_LEN_LSB], mem_rdata_in[7:0]};
                  IB_TX_LO: s_nxt.tx_base[15:0] = mem_rdata_in;
                  default: {s_nxt.tx_len, s_nxt.tx_base[23:16]} =
                     {mem_rdata_in[15:IB_LEN_LSB], mem_rdata_in[7:0]};
               endcase
               s_nxt.iw = s_r.iw + 3'h1;
               s_nxt.maddr = s_r.maddr + 24'h000002;
               if (s_nxt.iw == IB_WORDS)
               begin
                  s_nxt.mreq = 1'b0;
                  s_nxt.receive_ring_pointer = '0;
                  s_nxt.transmit_ring_pointer = '0;
                  s_nxt.rx_held = 1'b0;
                  s_nxt.idone = 1'b1;
                  s_nxt.st = S_SWITCH;
               end
            end
         S_LFW:
            if (s_r.receiver_on && !s_r.rx_held)
            begin
               s_nxt.st = S_RXPOLL;
               s_nxt.mreq = 1'b1;
               s_nxt.mwe = 1'b0;
               s_nxt.maddr = desc_addr(s_r.rx_base, s_r.receive_ring_pointer, DW_FLAGS);
            end
            else
               s_nxt.st = S_TXCHK;
         S_RXPOLL:
            if (mem_ack_in)
            begin
               s_nxt.mreq = 1'b0;
               s_nxt.rx_held = mem_rdata_in[W1_OWN_BIT];
               s_nxt.st = S_TXCHK;
            end
         S_TXCHK:
            if (s_r.transmitter_on)
            begin
               s_nxt.st = S_TXPOLL;
               s_nxt.mreq = 1'b1;
               s_nxt.mwe = 1'b0;
               s_nxt.maddr = desc_addr(s_r.tx_base, s_r.transmit_ring_pointer, DW_FLAGS);
            end
            else
               s_nxt.st = S_GAP;
         S_TXPOLL:
            if (mem_ack_in)
            begin
               s_nxt.cur_w1 = mem_rdata_in;
               s_nxt.mreq = 1'b0;
               s_nxt.st = S_GAP;
               if (mem_rdata_in[W1_OWN_BIT] && !mem_rdata_in[W1_STP_BIT])
               begin
                  // Invalid start: hand the descriptor back untouched
                  s_nxt.chain = 1'b0;
                  {s_nxt.buf_err, s_nxt.unf, s_nxt.late, s_nxt.car, s_nxt.retries_exhausted} = '0;
                  s_nxt.attempts = '0;
                  s_nxt.st = S_WR1;
                  s_nxt.mreq = 1'b1;
                  s_nxt.mwe = 1'b1;
                  s_nxt.mwdata = {1'b0, mem_rdata_in[14:0]};
               end
               else if (mem_rdata_in[W1_OWN_BIT])
               begin
                  s_nxt.st = S_TXRD0;
                  s_nxt.mreq = 1'b1;
                  s_nxt.maddr = desc_addr(s_r.tx_base, s_r.transmit_ring_pointer, DW_ADDR_LO);
               end
            end
         S_TXRD0:
            if (mem_ack_in)
            begin
               s_nxt.cur_w0 = mem_rdata_in;
               s_nxt.st = S_TXRD2;
               s_nxt.maddr = desc_addr(s_r.tx_base, s_r.transmit_ring_pointer, DW_SIZE);
            end
         S_TXRD2:
            if (mem_ack_in)
            begin
               s_nxt.cur_w2 = mem_rdata_in;
               s_nxt.mreq = 1'b0;
               s_nxt.tx_start = 1'b1;
               s_nxt.txing = 1'b1;
               {s_nxt.buf_err, s_nxt.unf, s_nxt.late, s_nxt.car, s_nxt.retries_exhausted} = '0;
               s_nxt.attempts = '0;
               s_nxt.tcnt = '0;
               s_nxt.cable_fault_distance = '0;
               s_nxt.bdone = 1'b0;
               s_nxt.nx_valid = 1'b0;
               s_nxt.pf_tried = 1'b0;
               s_nxt.st = S_TXRUN;
            end
         S_TXRUN:
            if (err_any)
            begin
               s_nxt.st = S_WR3;
               s_nxt.chain = 1'b0;
               s_nxt.mreq = 1'b1;
               s_nxt.mwe = 1'b1;
               s_nxt.maddr = desc_addr(s_r.tx_base, s_r.transmit_ring_pointer, DW_STATUS);
               s_nxt.mwdata = w3_wb;
            end
            else if (s_r.bdone && (s_r.cur_w1[W1_ENP_BIT] || s_r.nx_valid))
            begin
               // Buffer done: release it, chaining when a next one is held
               s_nxt.chain = !s_r.cur_w1[W1_ENP_BIT];
               s_nxt.st = S_WR1;
               s_nxt.mreq = 1'b1;
               s_nxt.mwe = 1'b1;
               s_nxt.maddr = desc_addr(s_r.tx_base, s_r.transmit_ring_pointer, DW_FLAGS);
               s_nxt.mwdata = w1_wb;
            end
            else if (s_r.bdone && s_r.pf_tried)
            begin
               s_nxt.buf_err = 1'b1;
               s_nxt.unf = 1'b1;
            end
            else if (!s_r.cur_w1[W1_ENP_BIT] && !s_r.pf_tried)
            begin
               s_nxt.st = S_PF1;
               s_nxt.mreq = 1'b1;
               s_nxt.mwe = 1'b0;
               s_nxt.maddr = desc_addr(s_r.tx_base, ring_next(s_r.transmit_ring_pointer, s_r.tx_len), DW_FLAGS);
            end
         S_PF1:
            if (mem_ack_in)
            begin
               s_nxt.nx_w1 = mem_rdata_in;
               s_nxt.pf_tried = 1'b1;
               s_nxt.mreq = mem_rdata_in[W1_OWN_BIT];
               s_nxt.st = mem_rdata_in[W1_OWN_BIT] ? S_PF0 : S_TXRUN;
               s_nxt.maddr = desc_addr(s_r.tx_base, ring_next(s_r.transmit_ring_pointer, s_r.tx_len), DW_ADDR_LO);
            end
         S_PF0:
            if (mem_ack_in)
            begin
               s_nxt.nx_w0 = mem_rdata_in;
               s_nxt.st = S_PF2;
               s_nxt.maddr = desc_addr(s_r.tx_base, ring_next(s_r.transmit_ring_pointer, s_r.tx_len), DW_SIZE);
            end
         S_PF2:
            if (mem_ack_in)
            begin
               s_nxt.nx_w2 = mem_rdata_in;
               s_nxt.nx_valid = 1'b1;
               s_nxt.mreq = 1'b0;
               s_nxt.st = S_TXRUN;
            end
         S_WR3:
            if (mem_ack_in)
            begin
               s_nxt.st = S_WR1;
               s_nxt.maddr = desc_addr(s_r.tx_base, s_r.transmit_ring_pointer, DW_FLAGS);
               s_nxt.mwdata = w1_wb;
            end
         S_WR1:
            if (mem_ack_in)
            begin
               s_nxt.mreq = 1'b0;
               s_nxt.transmit_ring_pointer = ring_next(s_r.transmit_ring_pointer, s_r.tx_len);
               if (s_r.chain)
               begin
                  {s_nxt.cur_w0, s_nxt.cur_w1, s_nxt.cur_w2} =
                     {s_r.nx_w0, s_r.nx_w1, s_r.nx_w2};
                  s_nxt.nx_valid = 1'b0;
                  s_nxt.pf_tried = 1'b0;
                  s_nxt.bdone = 1'b0;
                  s_nxt.tx_chain = 1'b1;
                  s_nxt.st = S_TXRUN;
               end
               else
               begin
                  s_nxt.did_tx = s_r.txing;
                  s_nxt.txing = 1'b0;
                  s_nxt.st = S_GAP;
               end
            end
         S_GAP:
            if (s_r.did_tx || s_r.transmit_demand)
            begin
               s_nxt.did_tx = 1'b0;
               s_nxt.transmit_demand = 1'b0;
               s_nxt.st = S_LFW;
            end
            else
            begin
               s_nxt.wait_cnt = WAIT_W'(WAIT_CYC - 1);
               s_nxt.st = S_WAIT;
            end
         S_WAIT:
            if (s_r.wait_cnt == '0 || s_r.transmit_demand)
               s_nxt.st = S_LFW;
            else
               s_nxt.wait_cnt = s_r.wait_cnt - WAIT_W'(1);
         default: s_nxt.st = S_SWITCH;
      endcase

      // Datapath stop on the first error of a buffer
      s_nxt.tx_abort = s_r.txing && !err_any &&
                       (s_nxt.buf_err | s_nxt.unf | s_nxt.late | s_nxt.car | s_nxt.retries_exhausted);

      // Host writes to the control registers
      if (csr_wr_in && csr_sel_in == CSR0_IDX)
      begin
         s_nxt.receiver_on = csr_wdata_in[CSR0_RECEIVER_ON_BIT];
         s_nxt.transmitter_on = csr_wdata_in[CSR0_TRANSMITTER_ON_BIT];
         if (csr_wdata_in[CSR0_TRANSMIT_DEMAND_BIT])
            s_nxt.transmit_demand = 1'b1;
         if (csr_wdata_in[CSR0_HALT_BIT])
         begin
            s_nxt.halt = 1'b1;
            s_nxt.init = 1'b0;
            s_nxt.run = 1'b0;
            s_nxt.idone = 1'b0;
            s_nxt.txing = 1'b0;
            s_nxt.mreq = 1'b0;
            s_nxt.st = S_SWITCH;
         end
         else if (csr_wdata_in[CSR0_INIT_BIT] || csr_wdata_in[CSR0_RUN_BIT])
         begin
            s_nxt.halt = 1'b0;
            s_nxt.init = s_r.init | csr_wdata_in[CSR0_INIT_BIT];
            s_nxt.run = s_r.run | csr_wdata_in[CSR0_RUN_BIT];
         end
      end
      if (csr_wr_in && s_r.halt && csr_sel_in == CSR1_IDX)
         s_nxt.csr1 = csr_wdata_in;
      if (csr_wr_in && s_r.halt && csr_sel_in == CSR2_IDX)
         s_nxt.csr2 = csr_wdata_in[7:0];
   end

   // State register
   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         s_r <= '0;
         s_r.halt <= CSR0_HALT_RST;
      end
      else
         s_r <= s_nxt;
   end

   // Outputs
   assign csr_rdata_out = s_r.csr_rdata;
   assign mem_req_out = s_r.mreq;
   assign mem_we_out = s_r.mwe;
   assign mem_addr_out = s_r.maddr;
   assign mem_wdata_out = s_r.mwdata;
   assign tx_start_out = s_r.tx_start;
   assign tx_chain_out = s_r.tx_chain;
   assign tx_retry_out = s_r.tx_retry;
   assign tx_abort_out = s_r.tx_abort;
   assign tx_addr_out = {s_r.cur_w1[7:0], s_r.cur_w0};
   assign tx_len_out = s_r.cur_w2[SIZE_W-1:0];
   assign rx_enter_out = s_r.rx_enter;

   // Checks
   halt_clears_run_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      csr_wr_in && csr_sel_in == CSR0_IDX && csr_wdata_in[CSR0_HALT_BIT]
      |=> s_r.halt && !s_r.init && !s_r.run && s_r.st == S_SWITCH)
      else $error("halt write did not stop the sequencer");
   txp_moves_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      $changed(s_r.transmit_ring_pointer) |-> $past(s_r.st == S_WR1 && mem_ack_in) || s_r.transmit_ring_pointer == 7'h00)
      else $error("transmit pointer moved without a release write");
   err_summary_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      s_r.st == S_WR1 && s_r.mwe && s_r.txing && err_sum |-> s_r.mwdata[W1_ERRSUM_BIT]
      && !s_r.mwdata[W1_OWN_BIT])
      else $error("release word lacks error summary");
   status_first_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      $rose(s_r.st == S_WR1) && err_any |-> $past(s_r.st) == S_WR3)
      else $error("ownership released before status written");
   retry_limit_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      $rose(s_r.retries_exhausted) |-> s_r.attempts == MAX_ATTEMPTS || s_r.mode[MODE_DISABLE_RETRY_BIT])
      else $error("retries exhausted at the wrong attempt");
   bufferr_underflow_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      s_r.buf_err |-> s_r.unf)
      else $error("buffer error without underflow");
   idle_wait_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      s_r.st == S_GAP && !s_r.did_tx && !s_r.transmit_demand
      && !(csr_wr_in && csr_sel_in == CSR0_IDX && csr_wdata_in[CSR0_HALT_BIT])
      |=> s_r.st == S_WAIT && s_r.wait_cnt == WAIT_W'(WAIT_CYC - 1))
      else $error("idle wait not started");
   init_ptrs_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      $rose(s_r.idone) |-> s_r.receive_ring_pointer == 7'h00 && s_r.transmit_ring_pointer == 7'h00 && !s_r.rx_held)
      else $error("pointers not reset by initialisation");
   late_noretry_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      s_r.txing && !err_any && collision_in && slot_elapsed_in
      |=> s_r.late && !s_r.tx_retry ##1 !s_r.tx_retry)
      else $error("late collision retried");

endmodule // lndrs_top
